// ### test_watchdog_reset_sources.sv
`timescale 1ns/1ps
`default_nettype none
module test_watchdog_reset_sources;
  import wdrs_pkg::*;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic t0 = 1'b0;
  logic c12Mode = 1'b0;
  logic eciIn = 1'b0;
  wdrs_sfr_req_s sfrReq = '0;
  logic [7:0] sfrRdData;
  logic resetPinDrive;
  logic deviceReset;
  int err_total = 0;
  int comparisons = 0;
  int cycles = 0;
  int rstSeen = 0;
  int pinSeen = 0;
  wdrs_top uut (.clk_sys(clk_sys), .sys_rst(sys_rst), .clk12Mode(c12Mode), .timer0Overflow(t0), .eciPin(eciIn),
    .sfrReq(sfrReq), .sfrRdData(sfrRdData), .resetPinDrive(resetPinDrive), .deviceReset(deviceReset));
  always #12.5 clk_sys = ~clk_sys;
  // Cycle limit and reset event tallies
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (deviceReset === 1'b1) rstSeen <= rstSeen + 1;
    if (resetPinDrive === 1'b1) pinSeen <= pinSeen + 1;
    if (cycles == 100000) begin
      err_total++;
      results();
    end
  end
  task automatic chk8(string what, logic [7:0] exp, logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chkn(string what, int exp, int got);
    comparisons++;
    if (got != exp) begin
      err_total++;
      $display("[ERR] %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  // One register access, strobe held for one cycle
  task automatic acc(logic w, logic [7:0] a, logic [7:0] d);
    @(posedge clk_sys);
    #2;
    sfrReq = '{w, !w, a, d};
    @(posedge clk_sys);
    #2;
    sfrReq = '0;
  endtask
  task automatic idle(int n);
    repeat (n) @(posedge clk_sys);
    #2;
  endtask
  task automatic tick(int n);
    repeat (n) begin
      idle(1);
      t0 = 1'b1;
      idle(1);
      t0 = 1'b0;
    end
  endtask
  task automatic m4_test;
    acc(1, 8'hC1, 8'h04);
    acc(1, 8'hC5, 8'h48);
    acc(1, 8'hC6, 8'h05);
    acc(1, 8'hC7, 8'h00);
    acc(1, 8'hC4, 8'h00);
    acc(1, 8'hC2, 8'h40);
    tick(8);
    idle(3);
    chkn("reset with enable clear", 0, rstSeen);
    acc(1, 8'hC3, 8'h00);
    acc(1, 8'hC1, 8'h44);
    acc(0, 8'hC1, 8'h00);
    chk8("array mode", 8'h44, sfrRdData);
    tick(4);
    idle(3);
    chkn("early match", 0, rstSeen);
    tick(1);
    idle(3);
    chkn("match reset", 1, rstSeen);
    chkn("pin on match", 0, pinSeen);
    $display("module watchdog test done");
  endtask
  // Timer sources: 12-clock machine cycle, half rate with compare moved ahead, count pin
  task automatic src_test;
    int t0c;
    c12Mode = 1'b1;
    acc(1, 8'hC5, 8'h48);
    acc(1, 8'hC6, 8'h03);
    acc(1, 8'hC7, 8'h00);
    acc(1, 8'hC1, 8'h40);
    acc(1, 8'hC2, 8'h40);
    t0c = cycles;
    while (deviceReset !== 1'b1 && cycles - t0c < 200) idle(1);
    chkn("12-clock match time", 1, int'(cycles - t0c >= 25 && cycles - t0c <= 36));
    acc(1, 8'hC5, 8'h48);
    acc(1, 8'hC6, 8'h08);
    acc(1, 8'hC7, 8'h00);
    acc(1, 8'hC1, 8'h42);
    acc(1, 8'hC2, 8'h40);
    idle(16);
    acc(1, 8'hC6, 8'h20);
    acc(1, 8'hC7, 8'h00);
    idle(20);
    chkn("reset after compare moved", 2, rstSeen);
    t0c = cycles;
    while (deviceReset !== 1'b1 && cycles - t0c < 200) idle(1);
    idle(2);
    chkn("half rate match", 3, rstSeen);
    acc(1, 8'hC5, 8'h48);
    acc(1, 8'hC6, 8'h02);
    acc(1, 8'hC7, 8'h00);
    acc(1, 8'hC1, 8'h46);
    acc(1, 8'hC2, 8'h40);
    eciIn = 1'b1;
    idle(4);
    eciIn = 1'b0;
    idle(4);
    chkn("one pin edge", 3, rstSeen);
    eciIn = 1'b1;
    idle(4);
    eciIn = 1'b0;
    idle(4);
    chkn("pin edge match", 4, rstSeen);
    chkn("pin on array match", 0, pinSeen);
    c12Mode = 1'b0;
    $display("timer source test done");
  endtask
  task automatic hw_test;
    int n;
    int t0c;
    acc(1, 8'hA6, 8'h1E);
    acc(1, 8'hA6, 8'hE1);
    acc(0, 8'hA6, 8'h00);
    chk8("key read", 8'h00, sfrRdData);
    idle(100);
    acc(1, 8'hA6, 8'h1E);
    acc(1, 8'hA6, 8'hE1);
    t0c = cycles;
    idle(100);
    acc(1, 8'hA6, 8'hE1);
    acc(1, 8'hA6, 8'h1E);
    acc(1, 8'hA6, 8'h55);
    while (deviceReset !== 1'b1 && cycles - t0c < 99000) idle(1);
    n = cycles - t0c;
    chkn("overflow in window", 1, int'(n >= 98286 && n <= 98310));
    idle(200);
    chkn("reset requests", 5, rstSeen);
    chkn("pin cycles", 98, pinSeen);
    $display("hardware watchdog test done");
  endtask
  task automatic results;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    idle(4);
    sys_rst = 1'b0;
    m4_test();
    src_test();
    hw_test();
    results();
  end
endmodule
`default_nettype wire

// ### wdrs_pkg.sv
package wdrs_pkg;
  // Special-function register access from the core
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] data;
  } wdrs_sfr_req_s;
  // Hardware watchdog key state, one-hot
  typedef enum logic [3:0] {
    WDRS_IDLE = 4'b0001,
    WDRS_IDLE_KEY = 4'b0010,
    WDRS_ARMED = 4'b0100,
    WDRS_ARMED_KEY = 4'b1000
  } wdrs_state_e;
endpackage

// ### wdrs_props.sv
`timescale 1ns/1ps
`default_nettype none
module wdrs_props (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic clk12Mode,
  input wire wdrs_pkg::wdrs_sfr_req_s sfrReq,
  input wire logic [7:0] sfrRdData,
  input wire logic resetPinDrive,
  input wire logic deviceReset
);
  import wdrs_pkg::*;
  logic [7:0] pinCnt_r;
  logic [7:0] pinCnt_nxt;
  // Length of the current reset pin pulse
  always_comb begin
    pinCnt_nxt = resetPinDrive ? pinCnt_r + 8'h01 : 8'h00;
  end
  always_ff @(posedge clk_sys) begin
    pinCnt_r <= pinCnt_nxt;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // Mode register write, then its read two cycles on
  sequence modeWr;
    sfrReq.wr && sfrReq.addr == 8'hC1;
  endsequence
  sequence modeRd;
    sfrReq.rd && sfrReq.addr == 8'hC1;
  endsequence
  a_pulse_single: assert property (deviceReset |=> !deviceReset)
    else $error("reset request longer than one cycle");
  a_pin_with_reset: assert property ($rose(resetPinDrive) |-> deviceReset)
    else $error("reset pin rose without reset request");
  a_pin_width_six: assert property ($fell(resetPinDrive) && !clk12Mode |-> pinCnt_r == 8'h62)
    else $error("reset pin pulse not 98 cycles");
  a_pin_width_twelve: assert property ($fell(resetPinDrive) && clk12Mode |-> pinCnt_r == 8'hC4)
    else $error("reset pin pulse not 196 cycles");
  a_pin_bounded: assert property (resetPinDrive |-> pinCnt_r < 8'hC4)
    else $error("reset pin pulse too long");
  a_reset_quiet: assert property ($fell(sys_rst) |-> (!deviceReset && !resetPinDrive) [*8])
    else $error("reset activity right after reset");
  a_unmapped_zero: assert property (sfrReq.rd && !(sfrReq.addr inside {[8'hC1:8'hC7]}) |=> sfrRdData == 8'h00)
    else $error("key or unmapped read not zero");
  a_mode_readback: assert property (modeWr ##2 modeRd |=> (sfrRdData & 8'h46) == ($past(sfrReq.data, 3) & 8'h46))
    else $error("mode register bits changed");
endmodule
bind wdrs_top wdrs_props chk (.clk_sys(clk_sys), .sys_rst(sys_rst), .clk12Mode(clk12Mode), .sfrReq(sfrReq),
  .sfrRdData(sfrRdData), .resetPinDrive(resetPinDrive), .deviceReset(deviceReset));
`default_nettype wire

// ### wdrs_regs.svh
// Operation
// - Hardware watchdog is off after every reset and does not count until armed.
// - Writing 1E then E1 to the key register at A6 arms the hardware watchdog.
// - Armed hardware watchdog adds one to its 14-bit count each machine cycle.
// - Software cannot disarm it; only hardware reset, overflow reset or module 4 watchdog match reset does.
// - Count reaching 3FFF is an overflow and resets the device.
// - Overflow drives reset pin high 98 oscillator periods, or 196 in 12-clock mode.
// - While armed, the 1E then E1 pair restarts the count.
// - Key register is write only; the count is neither readable nor writable.
// - Only module 4 has the watchdog; otherwise it serves its other modes.
// - Enabled module watchdog compares 16-bit compare value to array timer; match resets.
// - Module 4 watchdog reset leaves the reset pin low.
// - Clearing the enable bit before a match blocks the reset; setting re-enables.
// - Enable bit is mask 40 of the array mode register; other bits stay.
// - Compare enable plus match flag enable selects software-timer compare mode.
// - Enable bit lives in the array mode register and gates the module 4 watchdog.
`ifndef WDRS_REGS_SVH
`define WDRS_REGS_SVH
// Special-function addresses
`define WDRS_ADDR_SERVICE_KEY 8'hA6
`define WDRS_ADDR_ARRAY_MODE 8'hC1
`define WDRS_ADDR_ARRAY_CTRL 8'hC2
`define WDRS_ADDR_COUNT_LOW 8'hC3
`define WDRS_ADDR_COUNT_HIGH 8'hC4
`define WDRS_ADDR_MOD4_MODE 8'hC5
`define WDRS_ADDR_MOD4_CMP_LOW 8'hC6
`define WDRS_ADDR_MOD4_CMP_HIGH 8'hC7
// Service key bytes
`define WDRS_KEY_FIRST 8'h1E
`define WDRS_KEY_SECOND 8'hE1
// Field positions
`define WDRS_MODE_ARRAY_WATCHDOG_ENABLE_BIT 6
`define WDRS_MODE_CPS1_BIT 2
`define WDRS_MODE_CPS0_BIT 1
`define WDRS_CTRL_RUN_BIT 6
`define WDRS_M4_COMPARE_ENABLE_BIT 6
`define WDRS_M4_MAT_BIT 3
// Reset values
`define WDRS_RST_BYTE 8'h00
`define WDRS_RST_WORD 16'h0000
`define WDRS_RST_WDT_COUNT 14'h0000
// Timing counts; watchdog maximum in machine cycles, others in oscillator periods
`define WDRS_WDT_MAX 14'h3FFF
`define WDRS_MC_LAST_6CLK 4'h5
`define WDRS_MC_LAST_12CLK 4'hB
`define WDRS_HALF_LAST_6CLK 4'h1
`define WDRS_HALF_LAST_12CLK 4'h3
`define WDRS_PIN_PULSE_6CLK 8'd98
`define WDRS_PIN_PULSE_12CLK 8'd196
`endif

// ### wdrs_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "wdrs_regs.svh"
module wdrs_top (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic clk12Mode,
  input wire logic timer0Overflow,
  input wire logic eciPin,
  input wire wdrs_pkg::wdrs_sfr_req_s sfrReq,
  output logic [7:0] sfrRdData,
  output logic resetPinDrive,
  output logic deviceReset
);
  import wdrs_pkg::*;

  // Write strobe decode shared by all registers
  function automatic logic isWrite(input wdrs_sfr_req_s req, input logic [7:0] adr);
    isWrite = req.wr && (req.addr == adr);
  endfunction

  logic [3:0] mcCnt_r, mcCnt_nxt;
  logic [3:0] halfCnt_r, halfCnt_nxt;
  logic [2:0] eciSync_r, eciSync_nxt;
  logic [7:0] modeReg_r, modeReg_nxt;
  logic [7:0] ctrlReg_r, ctrlReg_nxt;
  logic [7:0] m4Mode_r, m4Mode_nxt;
  logic [15:0] count_r, count_nxt;
  logic [15:0] compare_r, compare_nxt;
  wdrs_state_e wdtState_r, wdtState_nxt;
  logic [13:0] wdtCnt_r, wdtCnt_nxt;
  logic [7:0] pulseCnt_r, pulseCnt_nxt;
  logic resetPin_r, resetPin_nxt;
  logic devRst_r, devRst_nxt;
  logic [7:0] rdData_r, rdData_nxt;
  logic mcTick;
  logic halfTick;
  logic eciEdge;
  logic timerTick;
  logic [15:0] countInc;
  logic arrayWdOn;
  logic arrayMatch;
  logic wdtArmed;
  logic wdtOverflow;
  logic selfRst;

  // Tick sources and watchdog events
  always_comb begin
    mcTick = (mcCnt_r == (clk12Mode ? `WDRS_MC_LAST_12CLK : `WDRS_MC_LAST_6CLK));
    halfTick = (halfCnt_r == (clk12Mode ? `WDRS_HALF_LAST_12CLK : `WDRS_HALF_LAST_6CLK));
    eciEdge = eciSync_r[1] && !eciSync_r[2];
    case ({modeReg_r[`WDRS_MODE_CPS1_BIT], modeReg_r[`WDRS_MODE_CPS0_BIT]})
      2'b00: timerTick = mcTick;
      2'b01: timerTick = halfTick;
      2'b10: timerTick = timer0Overflow;
      default: timerTick = eciEdge;
    endcase
    timerTick = timerTick && ctrlReg_r[`WDRS_CTRL_RUN_BIT];
    countInc = count_r + 16'h0001;
    // Only module 4 carries the watchdog; with ARRAY_WATCHDOG_ENABLE low it is a plain compare module
    arrayWdOn = modeReg_r[`WDRS_MODE_ARRAY_WATCHDOG_ENABLE_BIT] && m4Mode_r[`WDRS_M4_COMPARE_ENABLE_BIT]
      && m4Mode_r[`WDRS_M4_MAT_BIT];
    arrayMatch = arrayWdOn && timerTick && (countInc == compare_r);
    wdtArmed = (wdtState_r == WDRS_ARMED) || (wdtState_r == WDRS_ARMED_KEY);
    wdtOverflow = wdtArmed && (wdtCnt_r == `WDRS_WDT_MAX);
    selfRst = sys_rst || wdtOverflow || arrayMatch;
  end

  // Prescalers and external count input synchroniser
  always_comb begin
    mcCnt_nxt = mcTick ? 4'h0 : mcCnt_r + 4'h1;
    halfCnt_nxt = halfTick ? 4'h0 : halfCnt_r + 4'h1;
    eciSync_nxt = {eciSync_r[1:0], eciPin};
    if (sys_rst) begin
      mcCnt_nxt = 4'h0;
      halfCnt_nxt = 4'h0;
      eciSync_nxt = 3'b000;
    end
  end

  always_ff @(posedge clk_sys) begin
    mcCnt_r <= mcCnt_nxt;
    halfCnt_r <= halfCnt_nxt;
    eciSync_r <= eciSync_nxt;
  end

  // Counter-array registers and timer
  always_comb begin
    modeReg_nxt = modeReg_r;
    ctrlReg_nxt = ctrlReg_r;
    m4Mode_nxt = m4Mode_r;
    compare_nxt = compare_r;
    count_nxt = timerTick ? countInc : count_r;
    if (isWrite(sfrReq, `WDRS_ADDR_ARRAY_MODE)) begin
      modeReg_nxt = sfrReq.data;
    end
    if (isWrite(sfrReq, `WDRS_ADDR_ARRAY_CTRL)) begin
      ctrlReg_nxt = sfrReq.data;
    end
    if (isWrite(sfrReq, `WDRS_ADDR_MOD4_MODE)) begin
      m4Mode_nxt = sfrReq.data;
    end
    if (isWrite(sfrReq, `WDRS_ADDR_MOD4_CMP_LOW)) begin
      compare_nxt[7:0] = sfrReq.data;
    end
    if (isWrite(sfrReq, `WDRS_ADDR_MOD4_CMP_HIGH)) begin
      compare_nxt[15:8] = sfrReq.data;
    end
    if (isWrite(sfrReq, `WDRS_ADDR_COUNT_LOW)) begin
      count_nxt[7:0] = sfrReq.data;
    end
    if (isWrite(sfrReq, `WDRS_ADDR_COUNT_HIGH)) begin
      count_nxt[15:8] = sfrReq.data;
    end
    if (selfRst) begin
      modeReg_nxt = `WDRS_RST_BYTE;
      ctrlReg_nxt = `WDRS_RST_BYTE;
      m4Mode_nxt = `WDRS_RST_BYTE;
      compare_nxt = `WDRS_RST_WORD;
      count_nxt = `WDRS_RST_WORD;
    end
  end

  always_ff @(posedge clk_sys) begin
    modeReg_r <= modeReg_nxt;
    ctrlReg_r <= ctrlReg_nxt;
    m4Mode_r <= m4Mode_nxt;
    compare_r <= compare_nxt;
    count_r <= count_nxt;
  end

  // Hardware watchdog key sequence and count
  always_comb begin
    wdtState_nxt = wdtState_r;
    wdtCnt_nxt = wdtCnt_r;
    if (wdtArmed && mcTick) begin
      wdtCnt_nxt = wdtCnt_r + 14'h0001;
    end
    if (isWrite(sfrReq, `WDRS_ADDR_SERVICE_KEY)) begin
      if (sfrReq.data == `WDRS_KEY_FIRST) begin
        wdtState_nxt = wdtArmed ? WDRS_ARMED_KEY : WDRS_IDLE_KEY;
      end else if (sfrReq.data == `WDRS_KEY_SECOND
        && (wdtState_r == WDRS_IDLE_KEY || wdtState_r == WDRS_ARMED_KEY)) begin
        wdtState_nxt = WDRS_ARMED;
        wdtCnt_nxt = `WDRS_RST_WDT_COUNT;
      end else begin
        wdtState_nxt = wdtArmed ? WDRS_ARMED : WDRS_IDLE;
      end
    end
    if (selfRst) begin
      wdtState_nxt = WDRS_IDLE;
      wdtCnt_nxt = `WDRS_RST_WDT_COUNT;
    end
  end

  always_ff @(posedge clk_sys) begin
    wdtState_r <= wdtState_nxt;
    wdtCnt_r <= wdtCnt_nxt;
  end

  // Reset outputs: pin pulse only from the hardware watchdog
  always_comb begin
    pulseCnt_nxt = pulseCnt_r;
    if (pulseCnt_r != 8'd0) begin
      pulseCnt_nxt = pulseCnt_r - 8'd1;
    end
    if (wdtOverflow) begin
      pulseCnt_nxt = clk12Mode ? `WDRS_PIN_PULSE_12CLK : `WDRS_PIN_PULSE_6CLK;
    end
    resetPin_nxt = (pulseCnt_nxt != 8'd0);
    devRst_nxt = wdtOverflow || arrayMatch;
    if (sys_rst) begin
      pulseCnt_nxt = 8'd0;
      resetPin_nxt = 1'b0;
      devRst_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    pulseCnt_r <= pulseCnt_nxt;
    resetPin_r <= resetPin_nxt;
    devRst_r <= devRst_nxt;
  end

  // Read data; key register and watchdog count read as zero
  always_comb begin
    rdData_nxt = rdData_r;
    if (sfrReq.rd) begin
      if (sfrReq.addr == `WDRS_ADDR_ARRAY_MODE) begin
        rdData_nxt = modeReg_r;
      end else if (sfrReq.addr == `WDRS_ADDR_ARRAY_CTRL) begin
        rdData_nxt = ctrlReg_r;
      end else if (sfrReq.addr == `WDRS_ADDR_COUNT_LOW) begin
        rdData_nxt = count_r[7:0];
      end else if (sfrReq.addr == `WDRS_ADDR_COUNT_HIGH) begin
        rdData_nxt = count_r[15:8];
      end else if (sfrReq.addr == `WDRS_ADDR_MOD4_MODE) begin
        rdData_nxt = m4Mode_r;
      end else if (sfrReq.addr == `WDRS_ADDR_MOD4_CMP_LOW) begin
        rdData_nxt = compare_r[7:0];
      end else if (sfrReq.addr == `WDRS_ADDR_MOD4_CMP_HIGH) begin
        rdData_nxt = compare_r[15:8];
      end else begin
        rdData_nxt = 8'h00;
      end
    end
    if (sys_rst) begin
      rdData_nxt = 8'h00;
    end
  end

  always_ff @(posedge clk_sys) begin
    rdData_r <= rdData_nxt;
  end

  assign sfrRdData = rdData_r;
  assign resetPinDrive = resetPin_r;
  assign deviceReset = devRst_r;
endmodule
`default_nettype wire
